// *** core/adc_result_mem.v ***
// eight-entry result store with registered read data
`timescale 1ns/1ps
module adc_result_mem (
	// clock
	input wire clk_i,
	// write port
	input wire wr_en_i,
	input wire [2:0] wr_addr_i,
	input wire [9:0] wr_data_i,
	// read port
	input wire [2:0] rd_addr_i,
	output reg [9:0] rd_data_o
);
	reg [9:0] mem [0:7];

	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// *** core/adc_seq.v ***
// conversion sequencer for an 8-channel successive-approximation converter
//
// Notes on behaviour
// - every channel conversion not cut short by a stop command, sampling included, lasts exactly 92 clock cycles
// - sample-and-hold samples for 48 cycles before comparison steps start
// - successive approximation decides one bit per step, msb first, on held sample
// - 8-bit or 10-bit resolution; only needed comparison steps are done
// - single mode converts the start channel once, then waits for a new start
// - scan mode converts start channel up to end channel once, ascending
// - continuous mode repeats the channel run until software stops it
// - stop mode converts one channel, pauses, resumes with next on activation
// - conversion-complete interrupt raised when enabled
// - conversion-complete also pulses a transfer request to the dma engine
// - software start command begins conversion when software source selected
// - external trigger source starts a conversion on falling trigger edge
// - timer source starts a conversion on rising timer edge
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_seq (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// start sources
	input wire trg_ext_i,
	input wire timer_i,
	// analog front end
	input wire cmp_i,
	output reg sample_o,
	output reg [2:0] ch_sel_o,
	output reg [9:0] dac_code_o,
	// status and requests
	output reg busy_o,
	output reg dreq_o,
	output reg irq_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_PAUSE = 2'h2;

	reg [1:0] state;
	reg [31:0] ctrl;
	reg [`IRQ_BITS-1:0] irq_stat;
	reg [`IRQ_BITS-1:0] irq_mask;
	reg [6:0] cnt;
	reg [1:0] ph;
	reg [3:0] step;
	reg [2:0] cur;
	reg [9:0] last_res;
	reg ext_d;
	reg tmr_d;
	reg rd_wait;
	reg mem_we;
	reg [2:0] mem_wa;
	reg [9:0] mem_wd;
	wire [9:0] mem_rd;

	wire [1:0] mode = ctrl[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
	wire res10 = ctrl[`CTRL_RES10];
	wire [1:0] src = ctrl[`CTRL_SRC_LO+1:`CTRL_SRC_LO];
	wire [2:0] start_ch = ctrl[`CTRL_START_LO+2:`CTRL_START_LO];
	wire [2:0] end_ch = ctrl[`CTRL_END_LO+2:`CTRL_END_LO];
	wire [3:0] nbits = res10 ? 4'ha : 4'h8;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	wire req = cyc_i & stb_i & ~ack_o;
	wire [5:0] word = adr_i[7:2];
	wire res_hit = ({word[5:3], 3'h0} == `ADC_RES_BASE_OFS);
	wire wr_go = req & we_i & ~rd_wait;
	wire wr_ctrl = wr_go & (word == `ADC_CTRL_OFS);
	wire wr_cmd = wr_go & (word == `ADC_CMD_OFS);
	wire wr_clr = wr_go & (word == `ADC_IRQ_STAT_OFS);
	wire wr_mask = wr_go & (word == `ADC_IRQ_MASK_OFS);

	// byte-lane merge of a write into an existing word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// next channel of the run, wrapping from end back to start
	function [2:0] next_ch;
		input [2:0] c;
		input [2:0] s;
		input [2:0] e;
		begin
			next_ch = (c == e) ? s : c + 3'h1;
		end
	endfunction

	wire [31:0] cmd_w = merge(32'h0000_0000, dat_i, sel_i);
	wire [31:0] clr_w = merge(32'h0000_0000, dat_i, sel_i);
	wire sw_start = wr_cmd & cmd_w[`CMD_START];
	wire sw_stop = wr_cmd & cmd_w[`CMD_STOP];

	////////////////////////////////////////////////////////////////////////
	// start sources

	// inputs are synchronous; one stage is enough for edge detection
	wire ext_fall = ext_d & ~trg_ext_i;
	wire tmr_rise = ~tmr_d & timer_i;
	wire trig = (src == `SRC_SW && sw_start) |
		(src == `SRC_EXT && ext_fall) |
		(src == `SRC_TIMER && tmr_rise);

	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_d <= 1'b1;
			tmr_d <= 1'b1;
		end else begin
			ext_d <= trg_ext_i;
			tmr_d <= timer_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	wire conv_end = (state == ST_CONV) && (cnt == `CONV_CYCLES - 7'h1);
	wire sampling = (cnt < `SAMPLE_CYCLES);
	wire decide = (state == ST_CONV) && !sampling && (ph == `STEP_CYCLES) && (step < nbits);
	wire [9:0] bitpos = 10'h200 >> step;
	wire [9:0] final_code = (dac_code_o & ~(cmp_i ? 10'h000 : bitpos));
	wire [9:0] result = res10 ? final_code : {2'h0, final_code[9:2]};
	wire seq_last = (mode == `MODE_SINGLE) || (cur == end_ch);
	reg seq_evt;

	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cnt <= 7'h00;
			ph <= 2'h0;
			step <= 4'h0;
			cur <= 3'h0;
			dac_code_o <= 10'h000;
			sample_o <= 1'b0;
			busy_o <= 1'b0;
			dreq_o <= 1'b0;
			ch_sel_o <= 3'h0;
			last_res <= 10'h000;
			mem_we <= 1'b0;
			mem_wd <= 10'h000;
			mem_wa <= 3'h0;
			seq_evt <= 1'b0;
		end else begin
			dreq_o <= 1'b0;
			mem_we <= 1'b0;
			seq_evt <= 1'b0;
			case (state)
			ST_IDLE, ST_PAUSE: begin
				sample_o <= 1'b0;
				busy_o <= 1'b0;
				if (trig) begin
					// a paused stop-mode run resumes at the next channel of the run, already held in cur
					if (state == ST_IDLE) begin
						cur <= start_ch;
						ch_sel_o <= start_ch;
					end else begin
						ch_sel_o <= cur;
					end
					state <= ST_CONV;
					cnt <= 7'h00;
					ph <= 2'h0;
					step <= 4'h0;
					sample_o <= 1'b1;
					busy_o <= 1'b1;
					dac_code_o <= 10'h000;
				end else if (sw_stop) begin
					state <= ST_IDLE;
				end
			end
			ST_CONV: begin
				cnt <= cnt + 7'h1;
				if (cnt == `SAMPLE_CYCLES - 7'h1) begin
					sample_o <= 1'b0;
					dac_code_o <= 10'h200;
				end
				if (!sampling) begin
					ph <= ph + 2'h1;
				end
				if (decide) begin
					// keep the trial bit only when the held input is at or above it
					dac_code_o <= final_code | ((step + 4'h1 < nbits) ? bitpos >> 1 : 10'h000);
					step <= step + 4'h1;
				end
				if (sw_stop) begin
					// stop abandons the conversion in flight; no result is written
					state <= ST_IDLE;
					busy_o <= 1'b0;
					sample_o <= 1'b0;
				end else if (conv_end) begin
					last_res <= result;
					mem_we <= 1'b1;
					mem_wd <= result;
					// channel select advances at this edge in scan and continuous runs
					mem_wa <= ch_sel_o;
					dreq_o <= 1'b1;
					cnt <= 7'h00;
					ph <= 2'h0;
					step <= 4'h0;
					dac_code_o <= 10'h000;
					seq_evt <= seq_last;
					case (mode)
					`MODE_SINGLE: begin
						state <= ST_IDLE;
						busy_o <= 1'b0;
					end
					`MODE_SCAN: begin
						if (cur == end_ch) begin
							state <= ST_IDLE;
							busy_o <= 1'b0;
						end else begin
							cur <= cur + 3'h1;
							ch_sel_o <= cur + 3'h1;
							sample_o <= 1'b1;
						end
					end
					`MODE_CONT: begin
						cur <= next_ch(cur, start_ch, end_ch);
						ch_sel_o <= next_ch(cur, start_ch, end_ch);
						sample_o <= 1'b1;
					end
					default: begin
						cur <= next_ch(cur, start_ch, end_ch);
						state <= ST_PAUSE;
						busy_o <= 1'b0;
					end
					endcase
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// result of the conversion just finished, per channel
	adc_result_mem u_mem (
		.clk_i(clk_i),
		.wr_en_i(mem_we),
		.wr_addr_i(mem_wa),
		.wr_data_i(mem_wd),
		.rd_addr_i(word[2:0]),
		.rd_data_o(mem_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// interrupts

	wire [`IRQ_BITS-1:0] irq_set = {seq_evt, mem_we};
	wire [`IRQ_BITS-1:0] next_irq_stat = (irq_stat & ~(wr_clr ? clr_w[`IRQ_BITS-1:0] :
		{`IRQ_BITS{1'b0}})) | irq_set;
	wire [31:0] mask_w = merge({30'h0, irq_mask}, dat_i, sel_i);

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= {`IRQ_BITS{1'b0}};
			irq_mask <= {`IRQ_BITS{1'b0}};
			irq_o <= 1'b0;
		end else begin
			// a set in the clearing cycle survives
			irq_stat <= next_irq_stat;
			if (wr_mask) begin
				irq_mask <= mask_w[`IRQ_BITS-1:0];
			end
			irq_o <= |(next_irq_stat & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register access

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `CTRL_RESET;
			ack_o <= 1'b0;
			rd_wait <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= 1'b0;
			rd_wait <= 1'b0;
			if (wr_ctrl) begin
				ctrl <= merge(ctrl, dat_i, sel_i) & `CTRL_MASK;
			end
			if (rd_wait) begin
				ack_o <= 1'b1;
				dat_o <= {22'h0, mem_rd};
			end else if (req) begin
				// result reads wait one cycle for the registered store
				if (!we_i && res_hit) begin
					rd_wait <= 1'b1;
				end else begin
					ack_o <= 1'b1;
					dat_o <= 32'h0000_0000;
					if (!we_i) begin
						case (word)
						`ADC_CTRL_OFS: dat_o <= ctrl;
						`ADC_STAT_OFS: dat_o <= {6'h0, last_res, 9'h0, cur, 2'h0,
							(state == ST_PAUSE), busy_o};
						`ADC_IRQ_STAT_OFS: dat_o <= {30'h0, irq_stat};
						`ADC_IRQ_MASK_OFS: dat_o <= {30'h0, irq_mask};
						default: dat_o <= 32'h0000_0000;
						endcase
					end
				end
			end
		end
	end
endmodule

// *** core/adc_seq_map.vh ***
// register map, field positions, reset values and timing counts of the adc sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// word offsets (byte address bits 7:2)
`define ADC_CTRL_OFS 6'h00
`define ADC_CMD_OFS 6'h01
`define ADC_STAT_OFS 6'h02
`define ADC_IRQ_STAT_OFS 6'h03
`define ADC_IRQ_MASK_OFS 6'h04
`define ADC_RES_BASE_OFS 6'h08

// control fields
`define CTRL_MODE_LO 0
`define CTRL_RES10 2
`define CTRL_SRC_LO 3
`define CTRL_START_LO 8
`define CTRL_END_LO 12
`define CTRL_RESET 32'h0000_0000
`define CTRL_MASK 32'h0000_771f

// command bits
`define CMD_START 0
`define CMD_STOP 1

// modes and start sources
`define MODE_SINGLE 2'h0
`define MODE_SCAN 2'h1
`define MODE_CONT 2'h2
`define MODE_STOP 2'h3
`define SRC_SW 2'h0
`define SRC_EXT 2'h1
`define SRC_TIMER 2'h2

// interrupt status bits
`define IRQ_DONE 0
`define IRQ_SEQ 1
`define IRQ_BITS 2

// timing in machine cycles
`define CONV_CYCLES 7'h5c
`define SAMPLE_CYCLES 7'h30
`define STEP_CYCLES 2'h3

`endif

// *** test/adc_front_model.sv ***
// comparator and sample-and-hold model for the adc sequencer
`timescale 1ns/1ps
module adc_front_model (
	// converter side
	input wire logic clk_i,
	input wire logic sample_i,
	input wire logic [2:0] ch_i,
	input wire logic [9:0] code_i,
	// comparator
	output wire logic cmp_o
);
	logic [9:0] ana [8];
	logic [9:0] held;
	////////////////////////////////
	// tracks the input while sampling, frozen during the steps
	always @(posedge clk_i) begin
		if (sample_i)
			held <= ana[ch_i];
	end
	assign cmp_o = held >= code_i;
endmodule

// *** test/adc_seq_properties.sv ***
// port assertions for the adc sequencer
`timescale 1ns/1ps
module adc_seq_properties (
	// clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// converter
	input wire logic sample_o,
	input wire logic busy_o,
	input wire logic dreq_o,
	input wire logic irq_o,
	input wire logic [9:0] dac_code_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////
	// a stop command may cut a conversion short, hence the busy escape
	a_conv_len: assert property ($rose(sample_o) |-> ##92 (dreq_o || !busy_o))
		else $error("conversion length wrong");
	a_sample_len: assert property ($rose(sample_o) |->
		##47 (sample_o || !busy_o) ##1 !sample_o)
		else $error("sampling length wrong");
	a_first_trial: assert property ($fell(sample_o) && busy_o |-> dac_code_o == 10'h200)
		else $error("first trial code wrong");
	a_sample_busy: assert property (sample_o |-> busy_o)
		else $error("sampling while idle");
	a_busy_fall: assert property ($fell(busy_o) |-> dreq_o || ack_o)
		else $error("busy fell without cause");
	a_dreq_pulse: assert property (dreq_o |=> !dreq_o)
		else $error("transfer request too long");
	a_dreq_busy: assert property (dreq_o |-> $past(busy_o))
		else $error("transfer request while idle");
	a_irq_cause: assert property ($rose(irq_o) |-> $past(dreq_o) || $past(ack_o))
		else $error("interrupt without cause");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_req: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	c_conv: cover property (dreq_o);
	c_chain: cover property (dreq_o && busy_o);
	c_irq: cover property ($rose(irq_o));
endmodule

// *** test/tb_adc_seq.sv ***
// self-checking bench for the adc conversion sequencer
`timescale 1ns/1ps
module tb_adc_seq;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic trg_ext_i = 1'h1, timer_i = 1'h0;
	logic [7:0] adr_i = 8'h0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, rd;
	logic [2:0] ch;
	wire [31:0] dat_o;
	wire [9:0] dac_code_o;
	wire [2:0] ch_sel_o;
	wire ack_o, cmp_i, sample_o, busy_o, dreq_o, irq_o;
	int num_errors = 0, compares = 0, seed = 32'hcfb65f93;
	int since = 0;
	int q[$];
	adc_seq i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .trg_ext_i, .timer_i, .cmp_i, .sample_o, .ch_sel_o,
		.dac_code_o, .busy_o, .dreq_o, .irq_o);
	adc_front_model i_fe (.clk_i, .sample_i(sample_o), .ch_i(ch_sel_o),
		.code_i(dac_code_o), .cmp_o(cmp_i));
	// busy cycles since the trigger edge or the last transfer request
	always @(posedge clk_i)
		since <= (busy_o !== 1'h1 || dreq_o === 1'h1) ? 0 : since + 1;
	////////////////////////////////
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	task finish_test;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		sel_i <= 4'hf;
		adr_i <= a;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'h1 && k < 50);
		if (k >= 50) begin
			num_errors++;
			finish_test;
		end
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// n counts edges from the first sampling cycle to the request
	task conv(output logic [2:0] c, output int n);
		int k;
		k = 0;
		n = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (n == 0)
				c = ch_sel_o;
			if (n > 0 || sample_o === 1'h1)
				n++;
		end while (dreq_o !== 1'h1 && k < 400);
		if (k >= 400) begin
			num_errors++;
			finish_test;
		end
	endtask
	task run(input logic res10);
		logic [2:0] c;
		int n, e, first;
		first = 1;
		while (q.size() > 0) begin
			e = q.pop_front();
			conv(c, n);
			check(c, e);
			if (first)
				check(since, 92);
			first = 0;
			wb(1'h0, 8'(8'h20 + 4 * e), 32'h0);
			check(rd, res10 ? i_fe.ana[e] : i_fe.ana[e] >> 2);
		end
	endtask
	function logic [31:0] ctl(input logic [1:0] m, input logic r, input logic [1:0] s,
		input logic [2:0] a, input logic [2:0] b);
		return {17'h0, b, 1'h0, a, 3'h0, s, r, m};
	endfunction
	////////////////////////////////
	initial begin
		for (int k = 0; k < 8; k++)
			i_fe.ana[k] = 10'($random(seed));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, 8'h00, 32'h0);
		check(rd, 32'h0);
		wb(1'h1, 8'h1c, 32'hffff_ffff);
		wb(1'h0, 8'h1c, 32'h0);
		check(rd, 32'h0);
		wb(1'h1, 8'h10, 32'h1);
		for (int r = 0; r < 2; r++) begin
			ch = 3'($random(seed));
			q = '{ch};
			wb(1'h1, 8'h00, ctl(2'h0, r[0], 2'h0, ch, ch));
			wb(1'h1, 8'h04, 32'h1);
			run(r[0]);
			check(busy_o, 1'h0);
			check(irq_o, 1'h1);
			wb(1'h0, 8'h0c, 32'h0);
			check(rd, 32'h3);
			wb(1'h1, 8'h0c, 32'h3);
			check(irq_o, 1'h0);
		end
		$display("single end");
		q = '{6, 7, 0, 1};
		wb(1'h1, 8'h00, ctl(2'h1, 1'h1, 2'h0, 3'h6, 3'h1));
		wb(1'h1, 8'h04, 32'h1);
		run(1'h1);
		check(busy_o, 1'h0);
		$display("scan end");
		q = '{2, 3, 2, 3, 2};
		wb(1'h1, 8'h00, ctl(2'h2, 1'h1, 2'h0, 3'h2, 3'h3));
		wb(1'h1, 8'h04, 32'h1);
		run(1'h1);
		repeat (30) @(posedge clk_i);
		wb(1'h1, 8'h04, 32'h2);
		check(busy_o, 1'h0);
		// lets the aborted conversion's length window close
		repeat (100) @(posedge clk_i);
		$display("continuous end");
		wb(1'h1, 8'h00, ctl(2'h3, 1'h1, 2'h1, 3'h4, 3'h5));
		wb(1'h1, 8'h04, 32'h1);
		repeat (3) @(posedge clk_i);
		check(busy_o, 1'h0);
		for (int i = 0; i < 3; i++) begin
			q = '{i == 1 ? 5 : 4};
			trg_ext_i <= 1'h0;
			@(posedge clk_i);
			trg_ext_i <= 1'h1;
			run(1'h1);
			check(busy_o, 1'h0);
			wb(1'h0, 8'h08, 32'h0);
			check(rd, {6'h0, i_fe.ana[i == 1 ? 5 : 4], 9'h0, 3'(i == 1 ? 4 : 5), 4'h2});
		end
		$display("stop mode end");
		// leave the paused run so the next start takes the new start channel
		wb(1'h1, 8'h04, 32'h2);
		wb(1'h0, 8'h08, 32'h0);
		check(rd[1:0], 2'h0);
		q = '{7};
		wb(1'h1, 8'h00, ctl(2'h0, 1'h0, 2'h2, 3'h7, 3'h7));
		timer_i <= 1'h1;
		@(posedge clk_i);
		timer_i <= 1'h0;
		run(1'h0);
		$display("timer end");
		finish_test;
	end
endmodule
bind adc_seq adc_seq_properties i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
	.sample_o, .busy_o, .dreq_o, .irq_o, .dac_code_o);
